/* core/autx_baud.v */
`timescale 1ns/100ps
`default_nettype none
// Baud tick: one pulse every OVERSAMPLE*(divisor+1) clocks.
module autx_baud #(
	parameter OVERSAMPLE = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire [15:0] divisor,
	output reg tick
);
	reg [15:0] div_cnt;
	reg [3:0] os_cnt;
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			div_cnt <= 16'h0000;
			os_cnt <= 4'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (div_cnt >= divisor) begin
				div_cnt <= 16'h0000;
				if (os_cnt == OVERSAMPLE[3:0] - 4'h1) begin
					os_cnt <= 4'h0;
					tick <= 1'b1;
				end else begin
					os_cnt <= os_cnt + 4'h1;
				end
			end else begin
				div_cnt <= div_cnt + 16'h0001;
			end
		end
	end
endmodule // autx_baud
`default_nettype wire

/* core/autx_defines.vh */
`ifndef AUTX_DEFINES_VH
`define AUTX_DEFINES_VH
`define AUTX_OFF_CTRL 4'h0
`define AUTX_OFF_DIV 4'h4
`define AUTX_OFF_DATA 4'h8
`define AUTX_OFF_STAT 4'hC
`define AUTX_BIT_TRANSMITTER_ENABLE_BIT 0
`define AUTX_BIT_SERIAL_PORT_ENABLE 1
`define AUTX_BIT_SYNC 2
`define AUTX_BIT_HIGH_SPEED_BAUD_SELECT 3
`define AUTX_BIT_WIDE_DIVISOR_SELECT 4
`define AUTX_BIT_NINE 5
`define AUTX_BIT_IRQEN 6
`define AUTX_BIT_D8 7
`define AUTX_CTRL_RST 8'h00
`define AUTX_DIV_RST 16'h0000
`define AUTX_FLAG_DELAY 2'h2
`define AUTX_OVERSAMPLE 16
`endif

/* core/autx_top.v */
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "autx_defines.vh"
module autx_top (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg tx_line,
	output reg tx_line_oe,
	output reg irq
);
	reg [7:0] ctrl;
	reg [15:0] baud_divisor;
	reg [8:0] tx_holding_buffer;
	reg hold_full;
	reg [10:0] tx_shift_register;
	reg [3:0] bits_left;
	reg busy;
	reg tx_buffer_empty_flag;
	reg [1:0] flag_wait;
	reg irq_status;
	reg irq_mask;
	reg [3:0] aw_addr;
	reg aw_have;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_have;
	wire tick;
	wire transmitter_enable_bit = ctrl[`AUTX_BIT_TRANSMITTER_ENABLE_BIT];
	wire serial_port_enable = ctrl[`AUTX_BIT_SERIAL_PORT_ENABLE];
	wire async_run = transmitter_enable_bit & serial_port_enable & ~ctrl[`AUTX_BIT_SYNC];
	wire tx_irq_enable = ctrl[`AUTX_BIT_IRQEN];
	wire do_write = aw_have & w_have & ~s_axi_bvalid;
	wire wr_data = do_write && aw_addr == `AUTX_OFF_DATA && w_strb[0];
	wire empty_now = async_run & ~hold_full;
	wire load_shift = async_run & hold_full & ~busy;
	wire [8:0] new_char = {ctrl[`AUTX_BIT_D8], w_data[7:0]};
	// Low-speed wide mode is the only one modelled; divisor used at full width
	autx_baud #(.OVERSAMPLE(`AUTX_OVERSAMPLE)) u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(busy),
		.divisor(baud_divisor),
		.tick(tick)
	);
	// Write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl <= `AUTX_CTRL_RST;
			baud_divisor <= `AUTX_DIV_RST;
			irq_mask <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
			s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (aw_addr)
				`AUTX_OFF_CTRL: begin
					if (w_strb[0])
						ctrl <= w_data[7:0];
					if (w_strb[1])
						irq_mask <= w_data[8];
				end
				`AUTX_OFF_DIV: begin
					if (w_strb[0])
						baud_divisor[7:0] <= w_data[7:0];
					if (w_strb[1])
						baud_divisor[15:8] <= w_data[15:8];
				end
				`AUTX_OFF_DATA, `AUTX_OFF_STAT: begin
				end
				default: s_axi_bresp <= 2'b10;
				endcase
			end
		end
	end
	// Holding buffer, shifter and line
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_holding_buffer <= 9'h000;
			hold_full <= 1'b0;
			tx_shift_register <= 11'h7FF;
			bits_left <= 4'h0;
			busy <= 1'b0;
			tx_line <= 1'b1;
			tx_line_oe <= 1'b0;
		end else begin
			tx_line_oe <= serial_port_enable;
			if (!async_run) begin
				hold_full <= 1'b0;
				busy <= 1'b0;
				tx_line <= 1'b1;
			end else begin
				if (wr_data) begin
					tx_holding_buffer <= new_char;
					hold_full <= 1'b1;
				end
				if (load_shift) begin
					// Frame: stop, data, start; shifted out LSB first
					if (ctrl[`AUTX_BIT_NINE])
						tx_shift_register <= {1'b1, tx_holding_buffer, 1'b0};
					else
						tx_shift_register <= {2'b11, tx_holding_buffer[7:0], 1'b0};
					bits_left <= ctrl[`AUTX_BIT_NINE] ? 4'hB : 4'hA;
					busy <= 1'b1;
					hold_full <= wr_data;
					tx_line <= 1'b0;
				end else if (busy && tick) begin
					if (bits_left == 4'h1) begin
						busy <= 1'b0;
						tx_line <= 1'b1;
					end else begin
						tx_shift_register <= {1'b1, tx_shift_register[10:1]};
						tx_line <= tx_shift_register[1];
					end
					bits_left <= bits_left - 4'h1;
				end
			end
		end
	end
	// Flag follows buffer state, held for a fixed settle delay after each data write
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_buffer_empty_flag <= 1'b0;
			flag_wait <= 2'b00;
			irq_status <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_data)
				flag_wait <= `AUTX_FLAG_DELAY;
			else if (flag_wait != 2'b00)
				flag_wait <= flag_wait - 2'b01;
			if (!async_run)
				tx_buffer_empty_flag <= 1'b0;
			else if (flag_wait == 2'b00 || !transmitter_enable_bit)
				tx_buffer_empty_flag <= empty_now;
			// Sticky status: set wins over write-one-clear
			if (tx_buffer_empty_flag && tx_irq_enable)
				irq_status <= 1'b1;
			else if (do_write && aw_addr == `AUTX_OFF_STAT && w_strb[0] && w_data[0])
				irq_status <= 1'b0;
			irq <= irq_status & irq_mask & tx_irq_enable & tx_buffer_empty_flag;
		end
	end
	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`AUTX_OFF_CTRL: s_axi_rdata <= {23'h000000, irq_mask, ctrl};
				`AUTX_OFF_DIV: s_axi_rdata <= {16'h0000, baud_divisor};
				`AUTX_OFF_DATA: s_axi_rdata <= {23'h000000, tx_holding_buffer};
				`AUTX_OFF_STAT: s_axi_rdata <= {28'h0000000, busy, hold_full, tx_buffer_empty_flag, irq_status};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end
		end
	end
endmodule // autx_top
`default_nettype wire

/* verification/autx_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module autx_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic tx_line,
	input wire logic tx_line_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_IDLE: assert property (!tx_line_oe |-> tx_line) else $error("line low while off");
	AST_START: assert property ($fell(tx_line) |-> !tx_line [*8]) else $error("start bit short");
	AST_OE: assert property ($rose(tx_line_oe) |-> tx_line) else $error("not mark on enable");
	AST_WR: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid) else $error("no bvalid");
	AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("rdata moved");
	AST_RRESP: assert property (s_axi_rvalid |-> !s_axi_rresp[0]) else $error("bad rresp");
endmodule // autx_chk
`default_nettype wire

/* verification/autx_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module autx_rx_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic aclk,
	input wire logic rx,
	input wire logic nine,
	output logic [8:0] data,
	output int count
);
	integer i;
	initial begin
		count = 0;
		data = 9'h000;
		forever begin
			@(negedge rx);
			repeat (BIT_CLKS / 2) @(posedge aclk);
			for (i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge aclk);
				data[i] = rx;
			end
			// Ninth data bit only in nine-bit frames
			if (nine) begin
				repeat (BIT_CLKS) @(posedge aclk);
				data[8] = rx;
			end else begin
				data[8] = 1'b0;
			end
			repeat (BIT_CLKS) @(posedge aclk);
			// Bad stop bit drops the frame
			if (rx) count++;
		end
	end
endmodule // autx_rx_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "autx_defines.vh"
module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_line, tx_line_oe, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [8:0] rx_data;
	logic rx_nine = 1'h0;
	logic [1:0] br, rr;
	int rx_count;
	int err_count = 0;
	int checks = 0;
	always #4 aclk = ~aclk;
	autx_top dut_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.tx_line(tx_line),
		.tx_line_oe(tx_line_oe),
		.irq(irq)
	);
	autx_rx_model rx_u (.aclk(aclk), .rx(tx_line), .nine(rx_nine), .data(rx_data), .count(rx_count));
	// Ready raised only once the answer shows, so the slave must hold it a cycle
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rdt(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do begin
			@(posedge aclk);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Whole sequence needs well under 5000 clocks
	initial begin
		#300000;
		err_count++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h2, 32'h0);
		chk({31'h0, tx_line_oe}, 32'h0);
		wr(`AUTX_OFF_CTRL, 32'h3);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h2, 32'h2);
		chk({31'h0, tx_line_oe}, 32'h1);
		wr(`AUTX_OFF_DIV, 32'h1A0A);
		chk({30'h0, br}, 32'h0);
		rdt(`AUTX_OFF_DIV);
		chk(rd, 32'h1A0A);
		chk({30'h0, rr}, 32'h0);
		s_axi_wstrb <= 4'h1;
		wr(`AUTX_OFF_DIV, 32'h0000FF00);
		s_axi_wstrb <= 4'hF;
		rdt(`AUTX_OFF_DIV);
		chk(rd, 32'h1A00);
		wr(`AUTX_OFF_DIV, 32'h0);
		wr(`AUTX_OFF_STAT, 32'h2);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h2, 32'h2);
		$display("setup test done");
		wr(`AUTX_OFF_DATA, 32'hA5);
		wr(`AUTX_OFF_DATA, 32'h3C);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'hE, 32'hC);
		while (rx_count < 1) @(posedge aclk);
		chk({23'h0, rx_data}, 32'hA5);
		// Model counts at mid stop bit; hand-over follows the stop bit
		repeat (16) @(posedge aclk);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h6, 32'h2);
		while (rx_count < 2) @(posedge aclk);
		chk({23'h0, rx_data}, 32'h3C);
		$display("frame test done");
		rx_nine <= 1'h1;
		wr(`AUTX_OFF_CTRL, 32'hA3);
		wr(`AUTX_OFF_DATA, 32'h5A);
		while (rx_count < 3) @(posedge aclk);
		chk({23'h0, rx_data}, 32'h15A);
		$display("nine-bit test done");
		wr(`AUTX_OFF_CTRL, 32'h143);
		rdt(`AUTX_OFF_STAT);
		chk({31'h0, irq}, 32'h1);
		wr(`AUTX_OFF_CTRL, 32'h103);
		wr(`AUTX_OFF_STAT, 32'h1);
		rdt(`AUTX_OFF_STAT);
		chk({29'h0, rd[1:0], irq}, 32'h4);
		wr(`AUTX_OFF_CTRL, 32'h043);
		rdt(`AUTX_OFF_STAT);
		chk({30'h0, rd[0], irq}, 32'h2);
		wr(`AUTX_OFF_CTRL, 32'h7);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h2, 32'h0);
		wr(`AUTX_OFF_CTRL, 32'h0);
		rdt(`AUTX_OFF_STAT);
		chk(rd & 32'h2, 32'h0);
		chk({31'h0, tx_line_oe}, 32'h0);
		$display("irq test done");
		final_report();
	end
endmodule // tb
bind autx_top autx_chk chk_u (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.tx_line(tx_line),
	.tx_line_oe(tx_line_oe)
);
`default_nettype wire
